// >>> pbm_pkg.sv
// Constants and types shared by the basic mode control register block
package pbm_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [4:0] BMC_ADDR      = 5'h00;
    localparam int         BIT_RESET     = 15;
    localparam int         BIT_LOOPBACK  = 14;
    localparam int         BIT_SPEED     = 13;
    localparam int         BIT_AN_EN     = 12;
    localparam int         BIT_PWR_DOWN  = 11;
    localparam int         BIT_ISOLATE   = 10;
    localparam int         BIT_AN_RST    = 9;
    localparam int         BIT_DUPLEX    = 8;

    // ------------------------------------------------------------------
    // Reset values of the control fields
    // ------------------------------------------------------------------
    localparam logic       DEF_LOOPBACK  = 1'h0;
    localparam logic       DEF_SPEED     = 1'h1;
    localparam logic       DEF_AN_EN     = 1'h1;
    localparam logic       DEF_PWR_DOWN  = 1'h0;
    localparam logic       DEF_ISOLATE   = 1'h0;
    localparam logic       DEF_AN_RST    = 1'h0;
    localparam logic       DEF_DUPLEX    = 1'h1;

    // ------------------------------------------------------------------
    // Management frame layout
    // ------------------------------------------------------------------
    localparam logic [1:0] OP_READ       = 2'h2;
    localparam logic [1:0] OP_WRITE      = 2'h1;
    localparam logic [3:0] HDR_LAST      = 4'hB;
    localparam logic [3:0] TA_LAST       = 4'h1;
    localparam logic [3:0] DATA_LAST     = 4'hF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 20;
    localparam int         SRESET_TIME_NS = 10000;
    localparam int         SRESET_CYC_INT = (SRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] SRESET_CYCLES  = 10'(SRESET_CYC_INT);

    // Serial frame engine states
    typedef enum logic [2:0] {
        PBM_SER_IDLE,
        PBM_SER_START,
        PBM_SER_HDR,
        PBM_SER_TA,
        PBM_SER_DATA
    } pbm_ser_state_t;

endpackage

// >>> pbm_mgmt_serial.sv
// Serial management frame engine: decodes read and write frames
`timescale 1ns/100ps
module pbm_mgmt_serial
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [15:0] rd_data,
    output logic [4:0]       reg_addr,
    output logic             wr_stb,
    output logic [15:0]      wr_data
);

    pbm_pkg::pbm_ser_state_t state_q;
    logic [3:0]  cnt_q;
    logic [11:0] hdr_q;
    logic        one_seen_q;
    logic        mdc_q;
    logic [15:0] sh_q;
    logic        mdc_rise;
    logic        addr_hit;
    logic        read_hit;
    logic        write_hit;

    // ------------------------------------------------------------------
    // Header decode
    // ------------------------------------------------------------------
    assign mdc_rise  = mdc & ~mdc_q;
    assign addr_hit  = (hdr_q[9:5] == phy_addr);
    assign read_hit  = addr_hit && (hdr_q[11:10] == pbm_pkg::OP_READ);
    assign write_hit = addr_hit && (hdr_q[11:10] == pbm_pkg::OP_WRITE);
    assign reg_addr  = hdr_q[4:0];

    // Edge detect on the management clock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            mdc_q <= 1'h0;
        else if (ce)
            mdc_q <= mdc;
    end

    // Frame sequencer: preamble ones, start 01, header, turnaround, data
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q    <= pbm_pkg::PBM_SER_IDLE;
            cnt_q      <= 4'h0;
            hdr_q      <= 12'h000;
            one_seen_q <= 1'h0;
        end
        else if (ce && mdc_rise)
        begin
            case (state_q)
                pbm_pkg::PBM_SER_IDLE:
                begin
                    if (mdio_i)
                        one_seen_q <= 1'h1;
                    else if (one_seen_q)
                    begin
                        one_seen_q <= 1'h0;
                        state_q    <= pbm_pkg::PBM_SER_START;
                    end
                end
                pbm_pkg::PBM_SER_START:
                begin
                    cnt_q   <= 4'h0;
                    state_q <= mdio_i ? pbm_pkg::PBM_SER_HDR : pbm_pkg::PBM_SER_IDLE;
                end
                pbm_pkg::PBM_SER_HDR:
                begin
                    hdr_q <= {hdr_q[10:0], mdio_i};
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == pbm_pkg::HDR_LAST)
                    begin
                        cnt_q   <= 4'h0;
                        state_q <= pbm_pkg::PBM_SER_TA;
                    end
                end
                pbm_pkg::PBM_SER_TA:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == pbm_pkg::TA_LAST)
                    begin
                        cnt_q   <= 4'h0;
                        state_q <= pbm_pkg::PBM_SER_DATA;
                    end
                end
                pbm_pkg::PBM_SER_DATA:
                begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_q == pbm_pkg::DATA_LAST)
                        state_q <= pbm_pkg::PBM_SER_IDLE;
                end
                default:
                    state_q <= pbm_pkg::PBM_SER_IDLE;
            endcase
        end
    end

    // Data shifter, line driver and write strobe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mdio_o  <= 1'h0;
            mdio_oe <= 1'h0;
            sh_q    <= 16'h0000;
            wr_stb  <= 1'h0;
            wr_data <= 16'h0000;
        end
        else if (ce)
        begin
            wr_stb <= 1'h0;
            if (mdc_rise)
            begin
                case (state_q)
                    pbm_pkg::PBM_SER_TA:
                    begin
                        if (read_hit && cnt_q != pbm_pkg::TA_LAST)
                        begin
                            mdio_oe <= 1'h1; // Second turnaround bit driven low
                            mdio_o  <= 1'h0;
                        end
                        else if (read_hit)
                        begin
                            mdio_o <= rd_data[15];
                            sh_q   <= {rd_data[14:0], 1'h0};
                        end
                    end
                    pbm_pkg::PBM_SER_DATA:
                    begin
                        if (read_hit)
                        begin
                            mdio_o <= sh_q[15];
                            sh_q   <= {sh_q[14:0], 1'h0};
                            if (cnt_q == pbm_pkg::DATA_LAST)
                                mdio_oe <= 1'h0;
                        end
                        else if (write_hit)
                        begin
                            sh_q <= {sh_q[14:0], mdio_i};
                            if (cnt_q == pbm_pkg::DATA_LAST)
                            begin
                                wr_stb  <= 1'h1;
                                wr_data <= {sh_q[14:0], mdio_i};
                            end
                        end
                    end
                    default:
                        mdio_oe <= 1'h0;
                endcase
            end
        end
    end

endmodule

// >>> pbm_basic_mode_control.sv
// Basic mode control register, upper control bits, with MII gating
`timescale 1ns/100ps
//
// Function
// - Writing one to reset returns all control fields to defaults.
// - Reset bit defaults zero, reads one during reset sequence, then clears.
// - Loopback bit, default zero, loops transmit data into receive path.
// - Speed bit, default one, picks 100 or 10 Mbps when negotiation off.
// - With negotiation on, speed bit reads the negotiated speed.
// - Negotiation enable defaults one; speed and duplex then follow negotiation.
// - Power down bit, default zero; management stays answered while down.
// - No spurious MII transitions entering or during power down; clocks are ANDed with inverted pdn_q directly, so entry can cut a clock pulse short.
// - Isolate ignores transmit data, enable and error inputs.
// - Isolate floats clocks, receive lines, collision and carrier sense.
// - Management keeps working while isolated.
// - Writing one to restart begins negotiation again.
// - Restart ignored with negotiation disabled; host keeps it clear.
// - Restart bit reads one until negotiation has actually restarted.
// - Writing zero to restart leaves running negotiation untouched.
// - Duplex bit writable only with negotiation off; else reports negotiated.
module pbm_basic_mode_control
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        mdc,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        an_speed_100,
    input  wire logic        an_full_duplex,
    input  wire logic        an_started,
    output logic             an_enable,
    output logic             an_restart_req,
    output logic             speed_100,
    output logic             full_duplex,
    output logic             loopback_en,
    output logic             power_down,
    output logic             soft_reset,
    input  wire logic [3:0]  mii_txd_i,
    input  wire logic        mii_tx_en_i,
    input  wire logic        mii_tx_er_i,
    output logic [3:0]       core_txd,
    output logic             core_tx_en,
    output logic             core_tx_er,
    input  wire logic        core_tx_clk,
    input  wire logic        core_rx_clk,
    input  wire logic [3:0]  core_rxd,
    input  wire logic        core_rx_dv,
    input  wire logic        core_rx_er,
    input  wire logic        core_col,
    input  wire logic        core_crs,
    output logic             mii_tx_clk_o,
    output logic             mii_rx_clk_o,
    output logic [3:0]       mii_rxd_o,
    output logic             mii_rx_dv_o,
    output logic             mii_rx_er_o,
    output logic             mii_col_o,
    output logic             mii_crs_o,
    output logic             mii_out_oe
);

    logic        loop_q;
    logic        speed_q;
    logic        an_en_q;
    logic        pdn_q;
    logic        iso_q;
    logic        an_rst_q;
    logic        dup_q;
    logic        rst_busy_q;
    logic [9:0]  rst_cnt_q;
    logic [4:0]  reg_addr;
    logic        wr_stb;
    logic [15:0] wr_data;
    logic        wr_hit;
    logic [15:0] bmc_word;
    logic [15:0] rd_data;

    // ------------------------------------------------------------------
    // Management access
    // ------------------------------------------------------------------
    // Frame engine runs regardless of isolate and power down
    pbm_mgmt_serial u_serial
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .mdc      (mdc),
        .mdio_i   (mdio_i),
        .mdio_o   (mdio_o),
        .mdio_oe  (mdio_oe),
        .phy_addr (phy_addr),
        .rd_data  (rd_data),
        .reg_addr (reg_addr),
        .wr_stb   (wr_stb),
        .wr_data  (wr_data)
    );

    // Address decode; other addresses read zero and ignore writes
    assign wr_hit  = wr_stb && (reg_addr == pbm_pkg::BMC_ADDR);
    assign rd_data = (reg_addr == pbm_pkg::BMC_ADDR) ? bmc_word : 16'h0000;

    // Read view of the control word
    always_comb
    begin
        bmc_word                        = 16'h0000;
        bmc_word[pbm_pkg::BIT_RESET]    = rst_busy_q;
        bmc_word[pbm_pkg::BIT_LOOPBACK] = loop_q;
        bmc_word[pbm_pkg::BIT_SPEED]    = speed_100;
        bmc_word[pbm_pkg::BIT_AN_EN]    = an_en_q;
        bmc_word[pbm_pkg::BIT_PWR_DOWN] = pdn_q;
        bmc_word[pbm_pkg::BIT_ISOLATE]  = iso_q;
        bmc_word[pbm_pkg::BIT_AN_RST]   = an_rst_q;
        bmc_word[pbm_pkg::BIT_DUPLEX]   = full_duplex;
    end

    // ------------------------------------------------------------------
    // Software reset sequence
    // ------------------------------------------------------------------
    // Busy flag stands while the reset counter runs out
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rst_busy_q <= 1'h0;
            rst_cnt_q  <= 10'h000;
        end
        else if (ce)
        begin
            if (wr_hit && wr_data[pbm_pkg::BIT_RESET])
            begin
                rst_busy_q <= 1'h1;
                rst_cnt_q  <= pbm_pkg::SRESET_CYCLES;
            end
            else if (rst_busy_q)
            begin
                rst_cnt_q <= rst_cnt_q - 10'h001;
                if (rst_cnt_q == 10'h001)
                    rst_busy_q <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    // Writable fields, held at defaults through any reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            loop_q  <= pbm_pkg::DEF_LOOPBACK;
            speed_q <= pbm_pkg::DEF_SPEED;
            an_en_q <= pbm_pkg::DEF_AN_EN;
            pdn_q   <= pbm_pkg::DEF_PWR_DOWN;
            iso_q   <= pbm_pkg::DEF_ISOLATE;
            dup_q   <= pbm_pkg::DEF_DUPLEX;
        end
        else if (ce)
        begin
            if (rst_busy_q || (wr_hit && wr_data[pbm_pkg::BIT_RESET]))
            begin
                loop_q  <= pbm_pkg::DEF_LOOPBACK;
                speed_q <= pbm_pkg::DEF_SPEED;
                an_en_q <= pbm_pkg::DEF_AN_EN;
                pdn_q   <= pbm_pkg::DEF_PWR_DOWN;
                iso_q   <= pbm_pkg::DEF_ISOLATE;
                dup_q   <= pbm_pkg::DEF_DUPLEX;
            end
            else if (wr_hit)
            begin
                loop_q  <= wr_data[pbm_pkg::BIT_LOOPBACK];
                speed_q <= wr_data[pbm_pkg::BIT_SPEED];
                an_en_q <= wr_data[pbm_pkg::BIT_AN_EN];
                pdn_q   <= wr_data[pbm_pkg::BIT_PWR_DOWN];
                iso_q   <= wr_data[pbm_pkg::BIT_ISOLATE];
                if (!wr_data[pbm_pkg::BIT_AN_EN])
                    dup_q <= wr_data[pbm_pkg::BIT_DUPLEX];
            end
        end
    end

    // Restart request: set by a write of one, cleared once negotiation starts
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            an_rst_q <= pbm_pkg::DEF_AN_RST;
        else if (ce)
        begin
            if (rst_busy_q || (wr_hit && wr_data[pbm_pkg::BIT_RESET]))
                an_rst_q <= pbm_pkg::DEF_AN_RST;
            else if (wr_hit && wr_data[pbm_pkg::BIT_AN_RST] && wr_data[pbm_pkg::BIT_AN_EN])
                an_rst_q <= 1'h1;
            else if (an_started || !an_en_q)
                an_rst_q <= 1'h0;
        end
    end

    // Effective settings seen by the datapath
    assign an_enable      = an_en_q;
    assign an_restart_req = an_rst_q;
    assign speed_100      = an_en_q ? an_speed_100 : speed_q;
    assign full_duplex    = an_en_q ? an_full_duplex : dup_q;
    assign loopback_en    = loop_q;
    assign power_down     = pdn_q;
    assign soft_reset     = rst_busy_q;

    // ------------------------------------------------------------------
    // MII gating
    // ------------------------------------------------------------------
    // Transmit inputs are dropped while isolated
    assign core_txd   = iso_q ? 4'h0 : mii_txd_i;
    assign core_tx_en = iso_q ? 1'h0 : mii_tx_en_i;
    assign core_tx_er = iso_q ? 1'h0 : mii_tx_er_i;

    // Receive side outputs, quiet low while powered down
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mii_rxd_o   <= 4'h0;
            mii_rx_dv_o <= 1'h0;
            mii_rx_er_o <= 1'h0;
            mii_col_o   <= 1'h0;
            mii_crs_o   <= 1'h0;
            mii_out_oe  <= 1'h0;
        end
        else if (ce)
        begin
            mii_out_oe  <= ~iso_q;
            mii_rxd_o   <= pdn_q ? 4'h0 : core_rxd;
            mii_rx_dv_o <= ~pdn_q & core_rx_dv;
            mii_rx_er_o <= ~pdn_q & core_rx_er;
            mii_col_o   <= ~pdn_q & core_col;
            mii_crs_o   <= ~pdn_q & core_crs;
        end
    end

    // Clocks pass straight through, held low while powered down
    assign mii_tx_clk_o = ~pdn_q & core_tx_clk;
    assign mii_rx_clk_o = ~pdn_q & core_rx_clk;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sreset_defaults_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && wr_data[pbm_pkg::BIT_RESET]) |=> (!loop_q && speed_q && an_en_q && !pdn_q && !iso_q))
        else $error("soft reset did not restore defaults");
    sreset_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && wr_data[pbm_pkg::BIT_RESET]) |=> rd_data[pbm_pkg::BIT_RESET] [*8])
        else $error("reset bit not held during sequence");
    loopback_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && !rst_busy_q && !wr_data[pbm_pkg::BIT_RESET] && wr_data[pbm_pkg::BIT_LOOPBACK])
        |=> loopback_en)
        else $error("loopback not enabled by write");
    forced_speed_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && !rst_busy_q && !wr_data[pbm_pkg::BIT_RESET] && !wr_data[pbm_pkg::BIT_AN_EN])
        |=> (speed_100 == $past(wr_data[pbm_pkg::BIT_SPEED])))
        else $error("forced speed not applied");
    an_speed_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (an_en_q && reg_addr == pbm_pkg::BMC_ADDR) |-> (rd_data[pbm_pkg::BIT_SPEED] == an_speed_100))
        else $error("speed read does not show negotiated speed");
    an_duplex_a: assert property (@(posedge clk) disable iff (!rst_n)
        (an_en_q && reg_addr == pbm_pkg::BMC_ADDR) |-> (rd_data[pbm_pkg::BIT_DUPLEX] == an_full_duplex))
        else $error("duplex does not follow negotiation");
    isolate_tx_a: assert property (@(posedge clk) disable iff (!rst_n)
        iso_q |-> (!core_tx_en && !core_tx_er && core_txd == 4'h0))
        else $error("transmit inputs passed while isolated");
    isolate_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && iso_q) |=> !mii_out_oe)
        else $error("MII outputs driven while isolated");
    restart_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && !rst_busy_q && !wr_data[pbm_pkg::BIT_RESET]
         && wr_data[pbm_pkg::BIT_AN_EN] && wr_data[pbm_pkg::BIT_AN_RST]) |=> an_restart_req)
        else $error("restart request not raised");
    restart_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (an_restart_req && !an_started && an_en_q && !rst_busy_q
         && !(wr_hit && wr_data[pbm_pkg::BIT_RESET])) |=> an_restart_req)
        else $error("restart request dropped before start");
    // Forced duplex, end of the reset sequence, restart ignore and clear, and quiet outputs
    duplex_forced_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && !rst_busy_q && !wr_data[pbm_pkg::BIT_RESET] && !wr_data[pbm_pkg::BIT_AN_EN])
        |=> (full_duplex == $past(wr_data[pbm_pkg::BIT_DUPLEX])))
        else $error("forced duplex not applied");
    sreset_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && rst_busy_q && rst_cnt_q == 10'h001 && !(wr_hit && wr_data[pbm_pkg::BIT_RESET]))
        |=> !bmc_word[pbm_pkg::BIT_RESET])
        else $error("reset bit not cleared after sequence");
    restart_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && wr_hit && !wr_data[pbm_pkg::BIT_AN_EN] && !an_rst_q) |=> !an_restart_req)
        else $error("restart accepted with negotiation disabled");
    restart_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && an_started && !(wr_hit && wr_data[pbm_pkg::BIT_AN_RST] && wr_data[pbm_pkg::BIT_AN_EN]))
        |=> !an_restart_req)
        else $error("restart request not cleared by start");
    pdn_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && pdn_q) |=> (mii_rxd_o == 4'h0 && !mii_rx_dv_o && !mii_rx_er_o && !mii_col_o && !mii_crs_o))
        else $error("MII outputs active while powered down");

endmodule

// >>> pbm_sta_model.sv
// Station management model: drives serial read and write frames
`timescale 1ns/100ps
module pbm_sta_model
(
    input  wire logic clk,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output logic      mdc,
    output wire logic mdio
);
    logic drv_en;
    logic drv;

    // Wire level: device when enabled, else host, else the pull-up
    assign mdio = dev_oe ? dev_o : (drv_en ? drv : 1'b1);

    initial
    begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv = 1'b0;
    end

    // One management clock period, each phase two clocks long
    task automatic bit_cyc(input logic en, input logic v, output logic s);
        @(negedge clk);
        mdc = 1'b0;
        drv_en = en;
        drv = v;
        repeat (2) @(negedge clk);
        s = mdio;
        mdc = 1'b1;
        @(negedge clk);
    endtask

    // Whole frame: preamble, header, turnaround, 16 data bits MSB first
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdat);
        logic [13:0] hdr;
        logic        s;
        hdr = {2'h1, (rd ? 2'h2 : 2'h1), pa, ra};
        for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
        bit_cyc(!rd, 1'b1, s);
        bit_cyc(!rd, 1'b0, s);
        for (int i = 15; i >= 0; i--)
        begin
            bit_cyc(!rd, wd[i], s);
            rdat[i] = s;
        end
        @(negedge clk);
        drv_en = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// >>> pbm_basic_mode_control_bench.sv
// Testbench for the basic mode control register block
`timescale 1ns/100ps
module pbm_basic_mode_control_bench;
    localparam logic [4:0] PHY = 5'h05;
    logic clk = 1'b0, rst_n = 1'b0, mdc, mdio, mdio_o, mdio_oe;
    logic an_speed_100 = 1'b1, an_full_duplex = 1'b1, an_started = 1'b0;
    logic an_enable, an_restart_req, speed_100, full_duplex, loopback_en, power_down, soft_reset;
    logic [3:0] mii_txd_i = 4'hF, core_txd, core_rxd = 4'hF, mii_rxd_o;
    logic mii_tx_en_i = 1'b1, mii_tx_er_i = 1'b1, core_tx_en, core_tx_er;
    logic core_tx_clk = 1'b1, core_rx_clk = 1'b1, core_rx_dv = 1'b1, core_rx_er = 1'b1;
    logic core_col = 1'b1, core_crs = 1'b1;
    logic mii_tx_clk_o, mii_rx_clk_o, mii_rx_dv_o, mii_rx_er_o, mii_col_o, mii_crs_o, mii_out_oe;
    int   fail_count = 0;
    int   compares = 0;
    wire [7:0] flags = {an_enable, an_restart_req, speed_100, full_duplex,
                        loopback_en, power_down, soft_reset, mii_out_oe};
    wire [9:0] mii_out = {mii_tx_clk_o, mii_rx_clk_o, mii_rxd_o, mii_rx_dv_o,
                          mii_rx_er_o, mii_col_o, mii_crs_o};
    wire [5:0] core_tx = {core_txd, core_tx_en, core_tx_er};

    // Clock, 20 ns period
    always #10 clk = ~clk;

    pbm_sta_model sta (.clk(clk), .dev_o(mdio_o), .dev_oe(mdio_oe), .mdc(mdc), .mdio(mdio));

    pbm_basic_mode_control DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .mdc(mdc), .mdio_i(mdio),
        .mdio_o(mdio_o), .mdio_oe(mdio_oe), .phy_addr(PHY), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_started(an_started), .an_enable(an_enable),
        .an_restart_req(an_restart_req), .speed_100(speed_100), .full_duplex(full_duplex),
        .loopback_en(loopback_en), .power_down(power_down), .soft_reset(soft_reset),
        .mii_txd_i(mii_txd_i), .mii_tx_en_i(mii_tx_en_i), .mii_tx_er_i(mii_tx_er_i),
        .core_txd(core_txd), .core_tx_en(core_tx_en), .core_tx_er(core_tx_er),
        .core_tx_clk(core_tx_clk), .core_rx_clk(core_rx_clk), .core_rxd(core_rxd),
        .core_rx_dv(core_rx_dv), .core_rx_er(core_rx_er), .core_col(core_col),
        .core_crs(core_crs), .mii_tx_clk_o(mii_tx_clk_o), .mii_rx_clk_o(mii_rx_clk_o),
        .mii_rxd_o(mii_rxd_o), .mii_rx_dv_o(mii_rx_dv_o), .mii_rx_er_o(mii_rx_er_o),
        .mii_col_o(mii_col_o), .mii_crs_o(mii_crs_o), .mii_out_oe(mii_out_oe));

    // ------------------------------------------------------------------
    // Comparison, access and closing tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic fl(input logic [7:0] e);
        chk({8'h00, flags}, {8'h00, e});
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] d;
        sta.frame(1'b1, PHY, ra, 16'h0000, d);
        chk(d, e);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] v);
        logic [15:0] d;
        sta.frame(1'b0, PHY, ra, v, d);
    endtask

    task automatic summarize;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int i;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        fl(8'hB1);
        rd(5'h00, 16'h3100);
        an_speed_100 = 1'b0;
        an_full_duplex = 1'b0;
        rd(5'h00, 16'h1000);
        fl(8'h81);
        an_speed_100 = 1'b1;
        an_full_duplex = 1'b1;
        wr(5'h00, 16'h0000);
        fl(8'h01);
        rd(5'h00, 16'h0000);
        wr(5'h00, 16'h2300);
        fl(8'h31);
        rd(5'h00, 16'h2100);
        wr(5'h00, 16'h1200);
        fl(8'hF1);
        rd(5'h00, 16'h3300);
        wr(5'h00, 16'h1000);
        fl(8'hF1);
        an_started = 1'b1;
        @(negedge clk);
        an_started = 1'b0;
        @(negedge clk);
        fl(8'hB1);
        // Host leaves receive data unchecked right after loopback turns on
        wr(5'h00, 16'h5000);
        fl(8'hB9);
        wr(5'h00, 16'h1800);
        fl(8'hB5);
        chk({6'h00, mii_out}, 16'h0000);
        rd(5'h00, 16'h3900);
        wr(5'h00, 16'h1400);
        fl(8'hB0);
        chk({10'h000, core_tx}, 16'h0000);
        rd(5'h00, 16'h3500);
        wr(5'h00, 16'h5000);
        chk({10'h000, core_tx}, 16'h003F);
        chk({6'h00, mii_out}, 16'h03FF);
        wr(5'h01, 16'hFFFF);
        rd(5'h00, 16'h7100);
        rd(5'h01, 16'h0000);
        wr(5'h00, 16'hC000);
        fl(8'hB3);
        rd(5'h00, 16'hB100);
        for (i = 0; i < 400 && soft_reset !== 1'b0; i++) @(negedge clk);
        if (i == 400)
            fail_count++;
        else
        begin
            fl(8'hB1);
            rd(5'h00, 16'h3100);
        end
        summarize();
    end
endmodule
